// >>> verilog/sta_defines.svh
// Constants of the signal trace and analyzer block: offsets, fields, resets, timing.
// Assumes an APB master with 12-bit byte addresses and a 20 MHz pclk.
`ifndef STA_DEFINES_SVH
`define STA_DEFINES_SVH

`define STA_CLK_HZ        20000000
`define STA_TICK_MS       4
`define STA_TICK_CYC      (`STA_TICK_MS * (`STA_CLK_HZ / 1000))
`define STA_TICKS_PER_SEC 250
`define STA_SEC_MIN       4'h1
`define STA_SEC_MAX       4'ha

`define STA_OFS_CTRL      12'h000
`define STA_OFS_KEEP      12'h004
`define STA_OFS_TCFG      12'h008
`define STA_OFS_ACFG      12'h00c
`define STA_OFS_VADDR     12'h010
`define STA_OFS_VWDATA    12'h014
`define STA_OFS_VINDEX    12'h018
`define STA_OFS_VDATA     12'h01c
`define STA_OFS_STATUS    12'h020
`define STA_RGN_TRC       3'h1
`define STA_RGN_ANA       3'h2

`define STA_CMD_TRACE_EXECUTE_CMD      0
`define STA_CMD_TSTOP     1
`define STA_CMD_ASTART    2
`define STA_CMD_ASTOP     3
`define STA_CMD_SEARCH    4
`define STA_CMD_VWRITE    5
`define STA_KEEP_AUTO     5
`define STA_KEEP_WREN     4

`define STA_KEEP_RST      8'h00
`define STA_TCFG_RST      32'h0000_0000
`define STA_ACFG_RST      20'h0_0001
`define STA_NV_W          60

`define STA_NSIG          8
`define STA_TRC_N         128
`define STA_VIEW_BASE     24'h10_0000
`define STA_VIEW_SIZE     24'h00_0400
`define STA_VIEW_WIN      24'h00_0100

`endif

// >>> verilog/sta_pkg.sv
// Types of the signal trace and analyzer block.
// Assumes the constants header is on the include path.
`include "sta_defines.svh"
package sta_pkg;
  typedef enum logic [1:0] {
    ANA_IDLE = 2'b00,
    ANA_ARM  = 2'b01,
    ANA_RUN  = 2'b10,
    ANA_DONE = 2'b11
  } sta_ana_t;

  typedef struct packed {
    logic        boot;
    logic        autost;
    logic [7:0]  keep;
    logic [31:0] tcfg;
    logic [19:0] acfg;
    logic [23:0] vaddr;
    logic [1:0]  vwidth;
    logic [7:0]  vindex;
    logic [31:0] vwdata;
    logic        tracing;
    logic [6:0]  tptr;
    logic [15:0] last;
    sta_ana_t    ast;
    logic [6:0]  aptr;
    logic [31:0] tcnt;
    logic [11:0] wcnt;
    logic        trig_d;
    logic        sys_error;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sta_state_t;
endpackage : sta_pkg

// >>> verilog/sta_ring.sv
// Ring store of 128 two-byte entries with one-cycle clear.
// Assumes the owner keeps the write pointer; reads are combinational.
`timescale 1ns/1ps
`include "sta_defines.svh"
module sta_ring (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clear,
  input  wire logic        we,
  input  wire logic [6:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [6:0]  raddr,
  output logic      [15:0] rdata
);
  logic [15:0]            mem [`STA_TRC_N];
  logic [`STA_TRC_N-1:0]  valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid <= '0;
    end else if (clear) begin
      valid <= '0;
    end else if (we) begin
      valid[waddr] <= 1'b1;
    end
  end

  always_ff @(posedge pclk) begin
    if (we && !clear) begin
      mem[waddr] <= wdata;
    end
  end

  // Cleared entries read as zero
  assign rdata = valid[raddr] ? mem[raddr] : 16'h0000;
endmodule : sta_ring

// >>> verilog/sta_analyzer.sv
// Top of the signal trace and analyzer: APB registers, tracer, viewer, analyzer.
// Assumes sig_bytes and nv_image_in synchronous to pclk; nv store mirrors nv_image_out.
`timescale 1ns/1ps
`include "sta_defines.svh"
module sta_analyzer #(
  parameter int TICK_CYC = `STA_TICK_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [63:0]          sig_bytes,
  input  wire logic [`STA_NV_W-1:0] nv_image_in,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      sys_error,
  output logic                      tracing,
  output logic      [`STA_NV_W-1:0] nv_image_out
);
  sta_pkg::sta_state_t s;
  sta_pkg::sta_state_t n;

  logic [7:0]  vmem [`STA_VIEW_SIZE];
  logic [5:0]  cmd;
  logic        wr;
  logic [7:0]  m1;
  logic [7:0]  m2;
  logic [7:0]  tb;
  logic        trig;
  logic        rise;
  logic        fall;
  logic        evt;
  logic        tick;
  logic        trc_clr;
  logic        trc_we;
  logic        ana_clr;
  logic        ana_we;
  logic [15:0] trc_rd;
  logic [15:0] ana_rd;
  logic [11:0] win;
  logic [11:0] lim;
  logic [9:0]  voff;
  logic [2:0]  nb;
  logic [31:0] vdata;
  logic [31:0] wsh;
  logic        win_ok;
  logic        mem_we;

  // Picks a monitored byte; addresses beyond the inputs read zero
  function automatic logic [7:0] sel_byte(input logic [63:0] v, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a < 8'(`STA_NSIG)) begin
      r = v[{a[2:0], 3'b000} +: 8];
    end
    return r;
  endfunction : sel_byte

  assign prdata       = s.prdata;
  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign sys_error    = s.sys_error;
  assign tracing      = s.tracing;
  assign nv_image_out = {s.acfg, s.tcfg, s.keep};

  sta_ring u_trc (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (trc_clr),
    .we      (trc_we),
    .waddr   (s.tptr),
    .wdata   ({m1, m2}),
    .raddr   (paddr[8:2]),
    .rdata   (trc_rd)
  );

  sta_ring u_ana (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (ana_clr),
    .we      (ana_we),
    .waddr   (s.aptr),
    .wdata   ({m1, m2}),
    .raddr   (paddr[8:2]),
    .rdata   (ana_rd)
  );

  always_comb begin
    n       = s;
    trc_clr = 1'b0;
    trc_we  = 1'b0;
    ana_clr = 1'b0;
    ana_we  = 1'b0;
    mem_we  = 1'b0;
    wr      = psel && penable && s.pready && pwrite;
    cmd     = (wr && paddr == `STA_OFS_CTRL) ? pwdata[5:0] : 6'h00;
    m1      = sel_byte(sig_bytes, s.tcfg[7:0]) & s.tcfg[15:8];
    m2      = sel_byte(sig_bytes, s.tcfg[23:16]) & s.tcfg[31:24];
    tb      = sel_byte(sig_bytes, s.acfg[15:8]);
    trig    = tb[s.acfg[6:4]];
    rise    = trig && !s.trig_d;
    fall    = !trig && s.trig_d;
    n.trig_d = trig;
    unique case (s.acfg[17:16])
      2'h1:    evt = rise;
      2'h2:    evt = fall;
      default: evt = 1'b1;
    endcase
    win  = 12'(s.acfg[3:0] * `STA_TICKS_PER_SEC);
    lim  = (s.acfg[19:18] == 2'h1) ? {1'b0, win[11:1]} : win;
    tick = (s.tcnt == 32'(TICK_CYC - 1));
    n.tcnt = tick ? 32'h0000_0000 : s.tcnt + 32'h0000_0001;

    unique case (s.vwidth)
      2'h1:    nb = 3'h2;
      2'h2:    nb = 3'h4;
      default: nb = 3'h1;
    endcase
    voff   = 10'(s.vaddr - `STA_VIEW_BASE + 24'(s.vindex));
    win_ok = (s.vaddr >= `STA_VIEW_BASE) &&
             (s.vaddr <= `STA_VIEW_BASE + `STA_VIEW_SIZE - `STA_VIEW_WIN);
    vdata  = {vmem[voff], vmem[10'(voff + 10'h1)], vmem[10'(voff + 10'h2)],
              vmem[10'(voff + 10'h3)]} >> (6'(4 - nb) * 6'h8);
    wsh    = s.vwdata << (6'(4 - nb) * 6'h8);

    // APB: answer registered in the setup cycle, pready high in access
    n.pready = psel && !penable;
    if (psel && !penable) begin
      n.prdata  = 32'h0000_0000;
      n.pslverr = 1'b0;
      if (paddr[11:9] == `STA_RGN_TRC) begin
        n.prdata = {16'h0000, trc_rd};
      end else if (paddr[11:9] == `STA_RGN_ANA) begin
        n.prdata = {16'h0000, ana_rd};
      end else begin
        case (paddr)
          `STA_OFS_CTRL:   n.prdata = 32'h0000_0000;
          `STA_OFS_KEEP:   n.prdata = {24'h00_0000, s.keep};
          `STA_OFS_TCFG:   n.prdata = s.tcfg;
          `STA_OFS_ACFG:   n.prdata = {12'h000, s.acfg};
          `STA_OFS_VADDR:  n.prdata = {6'h00, s.vwidth, s.vaddr};
          `STA_OFS_VWDATA: n.prdata = s.vwdata;
          `STA_OFS_VINDEX: n.prdata = {24'h00_0000, s.vindex};
          // no data from an unused region
          `STA_OFS_VDATA: begin
            n.prdata  = s.sys_error ? 32'h0000_0000 : vdata;
            n.pslverr = s.sys_error;
          end
          `STA_OFS_STATUS: n.prdata = {12'h000, s.sys_error, s.ast, s.tracing,
                                       1'b0, s.aptr, 1'b0, s.tptr};
          default:         n.pslverr = 1'b1;
        endcase
      end
    end

    if (wr) begin
      case (paddr)
        `STA_OFS_KEEP: n.keep = pwdata[7:0];
        `STA_OFS_TCFG: n.tcfg = pwdata;
        `STA_OFS_ACFG: begin
          if (pwdata[3:0] >= `STA_SEC_MIN && pwdata[3:0] <= `STA_SEC_MAX) begin
            n.acfg = pwdata[19:0];
          end
        end
        `STA_OFS_VADDR: begin
          n.vaddr  = pwdata[23:0];
          n.vwidth = pwdata[25:24];
        end
        `STA_OFS_VWDATA: n.vwdata = pwdata;
        `STA_OFS_VINDEX: n.vindex = pwdata[7:0];
        default: ;
      endcase
    end

    n.boot   = 1'b0;
    n.autost = 1'b0;
    if (s.boot) begin
      n.keep   = nv_image_in[7:0];
      n.tcfg   = nv_image_in[39:8];
      n.acfg   = nv_image_in[59:40];
      n.autost = nv_image_in[`STA_KEEP_AUTO];
    end

    // power-on start when keep bit 5 set
    if (cmd[`STA_CMD_TRACE_EXECUTE_CMD] || s.autost) begin
      n.tracing = 1'b1;
      n.tptr    = 7'h00;
      n.last    = {m1, m2};
      trc_clr   = 1'b1;
    end else if (cmd[`STA_CMD_TSTOP]) begin
      n.tracing = 1'b0;
    end else if (s.tracing && {m1, m2} != s.last) begin
      trc_we = 1'b1;
      n.tptr = s.tptr + 7'h01;
      n.last = {m1, m2};
    end

    if (cmd[`STA_CMD_SEARCH]) begin
      n.sys_error = !win_ok;
      n.vindex    = 8'h00;
    end
    // write guard on keep bit 4
    if (cmd[`STA_CMD_VWRITE] && s.keep[`STA_KEEP_WREN] && !s.sys_error) begin
      mem_we = 1'b1;
    end

    // Analyzer
    if (cmd[`STA_CMD_ASTOP]) begin
      if (s.ast != sta_pkg::ANA_IDLE) begin
        n.ast = sta_pkg::ANA_DONE;
      end
    end else if (cmd[`STA_CMD_ASTART]) begin
      n.ast   = sta_pkg::ANA_ARM;
      n.aptr  = 7'h00;
      n.wcnt  = 12'h000;
      n.tcnt  = 32'h0000_0000;
      ana_clr = 1'b1;
    end else begin
      unique case (s.ast)
        sta_pkg::ANA_ARM: begin
          if (s.acfg[19:18] == 2'h3) begin
            if ((s.acfg[17:16] == 2'h0) ? tick : evt) begin
              ana_we = 1'b1;
            end
          end else begin
            // pre-trigger buffering in modes 1 and 2
            if (tick && s.acfg[19:18] != 2'h0) begin
              ana_we = 1'b1;
            end
            if (evt) begin
              n.wcnt = 12'h000;
              n.ast  = (s.acfg[19:18] == 2'h2) ? sta_pkg::ANA_DONE : sta_pkg::ANA_RUN;
            end
          end
        end
        sta_pkg::ANA_RUN: begin
          if (tick) begin
            ana_we = 1'b1;
            n.wcnt = s.wcnt + 12'h001;
            if (s.wcnt + 12'h001 >= lim) begin
              n.ast = sta_pkg::ANA_DONE;
            end
          end
        end
        sta_pkg::ANA_IDLE, sta_pkg::ANA_DONE: ;
      endcase
    end
    if (ana_we) begin
      n.aptr = s.aptr + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s        <= '0;
      s.boot   <= 1'b1;
      s.keep   <= `STA_KEEP_RST;
      s.tcfg   <= `STA_TCFG_RST;
      s.acfg   <= `STA_ACFG_RST;
      s.vaddr  <= `STA_VIEW_BASE;
      s.ast    <= sta_pkg::ANA_IDLE;
    end else begin
      s <= n;
    end
  end

  // Viewer memory, big-endian within the access width
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      for (int i = 0; i < 4; i++) begin
        if (3'(i) < nb) begin
          vmem[10'(voff + 10'(i))] <= wsh[8'(31 - 8 * i) -: 8];
        end
      end
    end
  end

  AST_TRACE_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    trc_we && s.tptr == 7'h7f |=> s.tptr == 7'h00)
    else $error("trace pointer did not wrap");

  AST_TRACE_START: assert property (@(posedge pclk) disable iff (!presetn)
    cmd[`STA_CMD_TRACE_EXECUTE_CMD] |=> s.tracing && s.tptr == 7'h00)
    else $error("execute did not restart trace");

  AST_TRACE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    s.tracing && {m1, m2} == s.last && !cmd[`STA_CMD_TRACE_EXECUTE_CMD] && !s.autost
      |=> $stable(s.tptr))
    else $error("trace recorded without change");

  AST_AUTO_START: assert property (@(posedge pclk) disable iff (!presetn)
    s.boot && nv_image_in[`STA_KEEP_AUTO] ##1 !cmd[`STA_CMD_TSTOP] |=> s.tracing)
    else $error("no automatic trace start");

  AST_VIEW_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    cmd[`STA_CMD_SEARCH] && !win_ok |=> s.sys_error)
    else $error("bad search address gave no error");

  AST_WRITE_GUARD: assert property (@(posedge pclk) disable iff (!presetn)
    !s.keep[`STA_KEEP_WREN] |-> !mem_we)
    else $error("viewer write while not enabled");

  AST_COND_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    s.ast == sta_pkg::ANA_ARM && s.acfg[19:16] == 4'h1 && !rise && cmd == 6'h00
      |=> s.ast == sta_pkg::ANA_ARM)
    else $error("armed analyzer left without rising edge");

  AST_BEFORE_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    s.ast == sta_pkg::ANA_ARM && s.acfg[19:18] == 2'h2 && evt && cmd == 6'h00
      |=> s.ast == sta_pkg::ANA_DONE ##1 $stable(s.aptr))
    else $error("before mode did not stop at trigger");

  AST_ONLY_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    s.ast == sta_pkg::ANA_ARM && cmd[`STA_CMD_ASTOP] |=> s.ast == sta_pkg::ANA_DONE)
    else $error("stop did not end recording");

  AST_SEC_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    !s.boot |-> s.acfg[3:0] >= `STA_SEC_MIN && s.acfg[3:0] <= `STA_SEC_MAX
      || $past(s.boot))
    else $error("sampling time out of range");

  AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready || (psel && !penable))
    else $error("pready not one cycle after setup");
endmodule : sta_analyzer

// >>> sim/sta_partner.sv
// Partner: monitored controller signal bytes and the nonvolatile config store.
// Assumes the bench sets sig_drive at rising pclk edges; store follows nv_image_out.
`timescale 1ns/1ps
`include "sta_defines.svh"
module sta_partner (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [63:0]          sig_drive,
  input  wire logic [`STA_NV_W-1:0] nv_image_out,
  output logic      [63:0]          sig_bytes,
  output logic      [`STA_NV_W-1:0] nv_image_in
);
  logic [1:0] settle;

  assign sig_bytes = sig_drive;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle <= 2'h0;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end
  end

  initial begin
    nv_image_in = {20'h00001, 32'h0000_0000, 8'h00};
    forever begin
      @(posedge pclk);
      if (settle == 2'h3) begin
        nv_image_in <= nv_image_out;
      end
    end
  end
endmodule : sta_partner

// >>> sim/tb_signal_trace_and_analyzer.sv
// Bench of the signal trace and analyzer: registers, tracer, viewer, analyzer.
// Assumes zero wait APB answers and the partner holding the config image.
`timescale 1ns/1ps
`include "sta_defines.svh"
module tb_signal_trace_and_analyzer;
  localparam int          TICK = 4;
  localparam logic [31:0] TCF  = 32'h0f03_ff00;
  logic                 pclk, presetn, psel, penable, pwrite;
  logic                 pready, pslverr, sys_error, tracing, er;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd, vw, seed, cyc;
  logic [63:0]          sig_drive, sig_bytes, sg;
  logic [`STA_NV_W-1:0] nv_i, nv_o;
  int                   miscompares, num_checks;
  int                   dl [3] = '{100 * TICK, 40 * TICK, 125 * TICK};

  sta_analyzer #(.TICK_CYC(TICK)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .sig_bytes(sig_bytes), .nv_image_in(nv_i), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_error(sys_error), .tracing(tracing), .nv_image_out(nv_o));
  sta_partner part_u (.pclk(pclk), .presetn(presetn), .sig_drive(sig_drive),
    .nv_image_out(nv_o), .sig_bytes(sig_bytes), .nv_image_in(nv_i));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'd40000) begin
      miscompares++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  function automatic logic [31:0] ent(input logic [63:0] s, input logic [31:0] t);
    return {16'h0, s[8 * t[2:0] +: 8] & t[15:8], s[8 * t[18:16] +: 8] & t[31:24]};
  endfunction : ent

  function automatic logic [31:0] ast(input int m, input int j);
    return (m == 2 || j == 2 || (j == 1 && m == 1)) ? 32'h3 : 32'h2;
  endfunction : ast

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask : rchk

  task automatic sig(input logic [63:0] v);
    @(posedge pclk);
    sig_drive <= v;
    repeat (2) @(posedge pclk);
  endtask : sig

  task automatic view(input logic [1:0] w, input logic [23:0] a, input logic [7:0] x);
    apb(1'b1, 12'h010, {6'h0, w, a});
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b1, 12'h018, {24'h0, x});
  endtask : view

  task automatic vwr(input logic [31:0] d);
    apb(1'b1, 12'h014, d);
    apb(1'b1, 12'h000, 32'h20);
  endtask : vwr

  task automatic rst;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : rst

  initial begin
    {psel, penable, pwrite, paddr, pwdata, sig_drive} = '0;
    presetn = 1'b0;
    cyc = 32'h0;
    seed = 32'h14;
    miscompares = 0;
    num_checks = 0;
    rst();
    chk("no auto", 32'h0, {31'h0, tracing});
    rchk("keep", 12'h004, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, 12'h00c, 32'hb);
    rchk("sec 11", 12'h00c, 32'h1);
    apb(1'b1, 12'h00c, 32'ha);
    rchk("sec 10", 12'h00c, 32'ha);
    $display("test registers done");
    seed = xs(seed);
    sg = {seed, ~seed};
    sg[7:0] = 8'h00;
    sig(sg);
    apb(1'b1, 12'h008, TCF);
    apb(1'b1, 12'h000, 32'h1);
    #1;
    chk("tracing", 32'h1, {31'h0, tracing});
    rchk("cleared", 12'h200, 32'h0);
    for (int i = 0; i <= 128; i++) begin
      seed = xs(seed);
      sg[31:0] = seed;
      sg[7:0] = i[7:0] + 8'h01;
      sig(sg);
      if (i == 0) rchk("entry0", 12'h200, ent(sg, TCF));
    end
    apb(1'b0, 12'h020, 32'h0);
    chk("wrap ptr", 32'h1, {25'h0, rd[6:0]});
    rchk("overwrite", 12'h200, ent(sg, TCF));
    sg[31:28] = ~sg[31:28];
    sig(sg);
    apb(1'b0, 12'h020, 32'h0);
    chk("masked", 32'h1, {25'h0, rd[6:0]});
    apb(1'b1, 12'h000, 32'h1);
    rchk("recleared", 12'h200, 32'h0);
    apb(1'b1, 12'h000, 32'h2);
    #1;
    chk("stop", 32'h0, {31'h0, tracing});
    apb(1'b1, 12'h004, 32'h30);
    repeat (5) @(posedge pclk);
    rst();
    chk("auto start", 32'h1, {31'h0, tracing});
    rchk("keep kept", 12'h004, 32'h30);
    rchk("tcfg kept", 12'h008, TCF);
    apb(1'b1, 12'h000, 32'h2);
    $display("test tracer done");
    view(2'h0, 24'h0f_f000, 8'h00);
    #1;
    chk("sys error", 32'h1, {31'h0, sys_error});
    apb(1'b0, 12'h01c, 32'h0);
    chk("no data", 32'h1, {31'h0, er});
    seed = xs(seed);
    vw = seed;
    view(2'h0, 24'h10_0010, 8'hff);
    vwr(vw);
    rchk("last byte", 12'h01c, {24'h0, vw[7:0]});
    view(2'h2, 24'h10_010c, 8'h00);
    apb(1'b0, 12'h01c, 32'h0);
    chk("window end", {24'h0, vw[7:0]}, {24'h0, rd[7:0]});
    view(2'h2, 24'h10_0010, 8'h00);
    vwr(vw);
    rchk("dword", 12'h01c, vw);
    view(2'h0, 24'h10_0010, 8'h01);
    rchk("byte", 12'h01c, {24'h0, vw[23:16]});
    view(2'h1, 24'h10_0010, 8'h02);
    vwr(32'h0f41);
    rchk("word", 12'h01c, 32'h0f41);
    apb(1'b1, 12'h004, 32'h0);
    view(2'h2, 24'h10_0010, 8'h00);
    vwr(~vw);
    rchk("guarded", 12'h01c, {vw[31:16], 16'h0f41});
    $display("test viewer done");
    sg = 64'h0;
    sig(sg);
    apb(1'b1, 12'h00c, 32'h000d_0201);
    apb(1'b1, 12'h000, 32'h4);
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      sg = {32'h0, seed[7:0], 8'h01, 8'h00, seed[15:8]};
      sig(sg);
      sg[16] = 1'b0;
      sig(sg);
      rchk("only", 12'h400 + 12'(4 * k), ent(sg, TCF));
    end
    apb(1'b0, 12'h020, 32'h0);
    chk("only count", 32'h3, {25'h0, rd[14:8]});
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b0, 12'h020, 32'h0);
    chk("only done", 32'h3, {30'h0, rd[18:17]});
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 12'h00c, {12'h0, m[1:0], (m == 0) ? 2'h2 : 2'h1, 16'h0201});
      apb(1'b1, 12'h000, 32'h4);
      repeat (20) @(posedge pclk);
      apb(1'b0, 12'h020, 32'h0);
      chk("armed", 32'h1, {30'h0, rd[18:17]});
      chk("pre", (m == 0) ? 32'h0 : 32'h1, {31'h0, rd[14:8] != 7'h0});
      sg[16] = 1'b1;
      sig(sg);
      sg[16] = 1'b0;
      sig(sg);
      apb(1'b0, 12'h020, 32'h0);
      chk("event", (m == 2) ? 32'h3 : 32'h2, {30'h0, rd[18:17]});
      for (int j = 0; j < 3; j++) begin
        repeat (dl[j]) @(posedge pclk);
        apb(1'b0, 12'h020, 32'h0);
        chk("window", ast(m, j), {30'h0, rd[18:17]});
      end
    end
    apb(1'b1, 12'h00c, 32'h0001_0631);
    apb(1'b1, 12'h000, 32'h4);
    sg[16] = 1'b1;
    sig(sg);
    apb(1'b0, 12'h020, 32'h0);
    chk("other bit", 32'h1, {30'h0, rd[18:17]});
    sg[51] = 1'b1;
    sig(sg);
    apb(1'b0, 12'h020, 32'h0);
    chk("trigger bit", 32'h2, {30'h0, rd[18:17]});
    apb(1'b1, 12'h00c, 32'h0000_0631);
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b0, 12'h020, 32'h0);
    chk("cond start", 32'h2, {30'h0, rd[18:17]});
    apb(1'b1, 12'h00c, 32'h000c_0631);
    apb(1'b1, 12'h000, 32'h4);
    repeat (20) @(posedge pclk);
    apb(1'b0, 12'h020, 32'h0);
    chk("only tick", 32'h1, {31'h0, rd[14:8] != 7'h0});
    $display("test analyzer done");
    end_of_test();
  end
endmodule : tb_signal_trace_and_analyzer
